// ===== design/mab_pkg.sv
// Purpose: shared constants for the alu / bit-op decoder and its file ram
// Assumes: 14-bit instruction words, 8-bit data, 128-byte register file
// Notes:   opcodes are matched on the top bits of the word
package mab_pkg;

  // ******************************************************************
  // widths and field positions
  // ******************************************************************
  localparam int INSTR_W   = 14;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 7;
  localparam int DEST_POS  = 7;   // destination select bit
  localparam int BPOS_LSB  = 7;   // bit position field low bit
  localparam int BPOS_W    = 3;
  localparam int NIB_W     = 4;
  localparam int PAGE_HI   = 9;   // pc bit loaded from status bit 5
  localparam int PAGE_LO   = 8;   // pc bit cleared by a short call
  localparam int SIMM_W    = 8;   // short call immediate
  localparam int GIMM_W    = 9;   // short jump immediate
  localparam int LIMM_W    = 11;  // long call / jump immediate

  // ******************************************************************
  // opcode patterns, each matched on the top bits of the word
  // ******************************************************************
  localparam logic [5:0] OPC_ADC   = 6'h1C;  // 01 1100
  localparam logic [5:0] OPC_SBC   = 6'h1D;  // 01 1101
  localparam logic [6:0] OPC_CMP   = 7'h3D;  // 01 1110 1
  localparam logic [5:0] OPC_CALLS = 6'h19;  // 01 1001
  localparam logic [4:0] OPC_GOTOS = 5'h0D;  // 01 101
  localparam logic [3:0] OPC_BCLR  = 4'hB;   // 10 11
  localparam logic [3:0] OPC_BSET  = 4'hA;   // 10 10
  localparam logic [3:0] OPC_BTSC  = 4'h9;   // 10 01
  localparam logic [3:0] OPC_BTSS  = 4'h8;   // 10 00
  localparam logic [2:0] OPC_LONG_CALL = 3'h6;   // 11 0
  localparam logic [2:0] OPC_LONG_JUMP = 3'h7;   // 11 1

  // ******************************************************************
  // reset values
  // ******************************************************************
  localparam logic [DATA_W-1:0]  WORK_RST  = 8'h00;
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

  // ******************************************************************
  // decoded operations and instruction-cycle phases
  // ******************************************************************
  typedef enum logic [3:0] {
    OP_NOP, OP_ADC, OP_SBC, OP_CMP, OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS,
    OP_CALLS, OP_GOTOS, OP_LONG_CALL, OP_LONG_JUMP
  } mab_op_t;

  typedef enum logic {PH_READ, PH_EXEC} mab_phase_t;

endpackage : mab_pkg

// ===== design/mab_rf_if.sv
// Purpose: carrier between the decoder core and its register-file ram
// Assumes: one port, read data registered one clock after the address
// Notes:   write and read share the address
`timescale 1ns/10ps
interface mab_rf_if;
  logic [mab_pkg::ADDR_W-1:0] addr;
  logic                       we;
  logic [mab_pkg::DATA_W-1:0] wdata;
  logic [mab_pkg::DATA_W-1:0] rdata;

  modport core (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface : mab_rf_if

// ===== design/mab_file_ram.sv
// Purpose: 128 x 8 file register ram with registered read data
// Assumes: single clock, synchronous active-high reset
// Notes:   contents are not cleared by reset, only the read register
`timescale 1ns/10ps
module mab_file_ram #(
  parameter int DEPTH = 128
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // core side
  mab_rf_if.mem     rf
);

  logic [mab_pkg::DATA_W-1:0] mem_reg [DEPTH];
  logic [mab_pkg::DATA_W-1:0] rdata_reg;

  // ******************************************************************
  // storage: read-before-write on one port, old data returned
  // ******************************************************************
  always_ff @(posedge i_clk)
  begin
    if (rf.we)
    begin
      mem_reg[rf.addr] <= rf.wdata;
    end
  end

  // read register keeps the ram a plain block-ram template
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rdata_reg <= mab_pkg::WORK_RST;
    end
    else
    begin
      rdata_reg <= mem_reg[rf.addr];
    end
  end

  assign rf.rdata = rdata_reg;

endmodule : mab_file_ram

// ===== design/mab_core.sv
// Purpose: decode and run carry arithmetic, bit ops, calls and jumps
// Assumes: program memory answers o_pc with i_instr in the same clock
// Notes:   one instruction cycle is two clocks: read then execute
`timescale 1ns/10ps

// What this block does
// - 01 1100 d r decodes as add with carry, flags carry/half/zero.
// - 01 1101 d r: register minus work minus borrow, updates three flags.
// - skip-if-clear skips next word when tested bit is zero.
// - skip-if-set skips next word when bit is one; flags untouched.
// - destination bit zero: result to work register, file untouched.
// - destination bit one: result written back into the file register.
// - add sums work, file register and carry; address 0 to 127.
// - short call pushes pc+1, loads 8-bit immediate, two cycles.
// - short call copies status bit five to pc bit nine, clears eight.
module mab_core #(
  parameter int PC_W = 11
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // program memory
  input  wire logic [13:0]       i_instr,
  output logic      [PC_W-1:0]   o_pc,
  // status bit 5 from the status register
  input  wire logic              i_page_bit,
  // return stack push
  output logic                   o_push,
  output logic      [PC_W-1:0]   o_push_addr,
  // processor state
  output logic      [7:0]        o_work,
  output logic                   o_carry,
  output logic                   o_half_carry,
  output logic                   o_zero,
  output logic                   o_cycle_done,
  output logic                   o_discard
);

  mab_rf_if rf ();

  mab_file_ram #(.DEPTH(128)) u_ram (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .rf        (rf.mem)
  );

  // ******************************************************************
  // decode, shared by the execute logic and the checks
  // ******************************************************************
  function automatic mab_pkg::mab_op_t decode_op(
    input logic [mab_pkg::INSTR_W-1:0] w);
    mab_pkg::mab_op_t op;
    op = mab_pkg::OP_NOP;
    if (w[13:8] == mab_pkg::OPC_ADC)        op = mab_pkg::OP_ADC;
    else if (w[13:8] == mab_pkg::OPC_SBC)   op = mab_pkg::OP_SBC;
    else if (w[13:7] == mab_pkg::OPC_CMP)   op = mab_pkg::OP_CMP;
    else if (w[13:8] == mab_pkg::OPC_CALLS) op = mab_pkg::OP_CALLS;
    else if (w[13:9] == mab_pkg::OPC_GOTOS) op = mab_pkg::OP_GOTOS;
    else if (w[13:10] == mab_pkg::OPC_BCLR) op = mab_pkg::OP_BCLR;
    else if (w[13:10] == mab_pkg::OPC_BSET) op = mab_pkg::OP_BSET;
    else if (w[13:10] == mab_pkg::OPC_BTSC) op = mab_pkg::OP_BTSC;
    else if (w[13:10] == mab_pkg::OPC_BTSS) op = mab_pkg::OP_BTSS;
    else if (w[13:11] == mab_pkg::OPC_LONG_CALL) op = mab_pkg::OP_LONG_CALL;
    else if (w[13:11] == mab_pkg::OPC_LONG_JUMP) op = mab_pkg::OP_LONG_JUMP;
    return op;
  endfunction : decode_op

  // ******************************************************************
  // state
  // ******************************************************************
  mab_pkg::mab_phase_t         phase_reg,   phase_next;
  logic [13:0]                 instr_reg,   instr_next;
  logic [PC_W-1:0]             pc_reg,      pc_next;
  logic [7:0]                  work_reg,    work_next;
  logic                        carry_reg,   carry_next;
  logic                        half_reg,    half_next;
  logic                        zero_reg,    zero_next;
  logic                        discard_reg, discard_next;

  // execute-phase working values
  mab_pkg::mab_op_t            op;
  logic [7:0]                  fr;
  logic [7:0]                  b_op;
  logic                        cin;
  logic [8:0]                  sum9;
  logic [4:0]                  nib5;
  logic [7:0]                  alu_res;
  logic [7:0]                  mask;
  logic                        tbit;
  logic                        dest_file;
  logic                        exec;

  assign exec      = (phase_reg == mab_pkg::PH_EXEC) && !discard_reg;
  assign op        = exec ? decode_op(instr_reg) : mab_pkg::OP_NOP;
  assign fr        = rf.rdata;
  assign dest_file = instr_reg[mab_pkg::DEST_POS];
  assign mask      = 8'h01 << instr_reg[mab_pkg::BPOS_LSB +: mab_pkg::BPOS_W];
  assign tbit      = |(fr & mask);

  // ******************************************************************
  // alu: subtract is register plus inverted work plus carry (no borrow)
  // ******************************************************************
  always_comb
  begin
    b_op = (op == mab_pkg::OP_ADC) ? work_reg : ~work_reg;
    cin  = (op == mab_pkg::OP_CMP) ? 1'b1 : carry_reg;
    sum9 = {1'b0, fr} + {1'b0, b_op} + {8'h00, cin};
    nib5 = {1'b0, fr[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
    alu_res = sum9[7:0];
  end

  // ******************************************************************
  // next state: ram access, flags, destination, pc and skip
  // ******************************************************************
  always_comb
  begin
    phase_next   = phase_reg;
    instr_next   = instr_reg;
    pc_next      = pc_reg;
    work_next    = work_reg;
    carry_next   = carry_reg;
    half_next    = half_reg;
    zero_next    = zero_reg;
    discard_next = discard_reg;
    rf.addr      = instr_reg[mab_pkg::ADDR_W-1:0];
    rf.we        = 1'b0;
    rf.wdata     = alu_res;
    o_push       = 1'b0;
    if (phase_reg == mab_pkg::PH_READ)
    begin
      // address the operand so read data lands for the execute clock
      rf.addr    = i_instr[mab_pkg::ADDR_W-1:0];
      instr_next = i_instr;
      phase_next = mab_pkg::PH_EXEC;
    end
    else
    begin
      phase_next   = mab_pkg::PH_READ;
      pc_next      = pc_reg + PC_W'(1);
      discard_next = 1'b0;       // a discarded slot never chains
      unique case (op)
        mab_pkg::OP_ADC, mab_pkg::OP_SBC:
        begin
          carry_next = sum9[8];
          half_next  = nib5[4];
          zero_next  = (alu_res == 8'h00);
          if (dest_file)
          begin
            rf.we = 1'b1;
          end
          else
          begin
            work_next = alu_res;
          end
        end
        mab_pkg::OP_CMP:
        begin
          carry_next = sum9[8];
          zero_next  = (alu_res == 8'h00);
        end
        mab_pkg::OP_BCLR:
        begin
          rf.we    = 1'b1;
          rf.wdata = fr & ~mask;
        end
        mab_pkg::OP_BSET:
        begin
          rf.we    = 1'b1;
          rf.wdata = fr | mask;
        end
        mab_pkg::OP_BTSC: discard_next = !tbit;
        mab_pkg::OP_BTSS: discard_next = tbit;
        mab_pkg::OP_CALLS:
        begin
          o_push       = 1'b1;
          pc_next      = PC_W'(instr_reg[mab_pkg::SIMM_W-1:0]);
          pc_next[mab_pkg::PAGE_HI] = i_page_bit;
          pc_next[mab_pkg::PAGE_LO] = 1'b0;
          discard_next = 1'b1;
        end
        mab_pkg::OP_GOTOS:
        begin
          pc_next      = PC_W'(instr_reg[mab_pkg::GIMM_W-1:0]);
          pc_next[mab_pkg::PAGE_HI] = i_page_bit;
          discard_next = 1'b1;
        end
        mab_pkg::OP_LONG_CALL:
        begin
          o_push       = 1'b1;
          pc_next      = PC_W'(instr_reg[mab_pkg::LIMM_W-1:0]);
          discard_next = 1'b1;
        end
        mab_pkg::OP_LONG_JUMP:
        begin
          pc_next      = PC_W'(instr_reg[mab_pkg::LIMM_W-1:0]);
          discard_next = 1'b1;
        end
        mab_pkg::OP_NOP: ;
      endcase
    end
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      phase_reg   <= mab_pkg::PH_READ;
      instr_reg   <= mab_pkg::INSTR_RST;
      pc_reg      <= '0;
      work_reg    <= mab_pkg::WORK_RST;
      carry_reg   <= 1'b0;
      half_reg    <= 1'b0;
      zero_reg    <= 1'b0;
      discard_reg <= 1'b0;
    end
    else
    begin
      phase_reg   <= phase_next;
      instr_reg   <= instr_next;
      pc_reg      <= pc_next;
      work_reg    <= work_next;
      carry_reg   <= carry_next;
      half_reg    <= half_next;
      zero_reg    <= zero_next;
      discard_reg <= discard_next;
    end
  end

  // outputs straight from flops except the push pair, which is combinational from op and pc_reg
  assign o_pc         = pc_reg;
  assign o_push_addr  = pc_reg + PC_W'(1);
  assign o_work       = work_reg;
  assign o_carry      = carry_reg;
  assign o_half_carry = half_reg;
  assign o_zero       = zero_reg;
  assign o_cycle_done = (phase_reg == mab_pkg::PH_EXEC);
  assign o_discard    = discard_reg;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_adc_work_sum: assert property (op == mab_pkg::OP_ADC && !dest_file
    |=> work_reg == $past(work_reg) + $past(fr) + 8'($past(carry_reg)))
    else $error("add with carry result wrong");
  a_adc_flags_set: assert property ((op == mab_pkg::OP_ADC)
    |=> carry_reg == $past(sum9[8]) && zero_reg == ($past(alu_res) == 8'h00)
        && half_reg == $past(nib5[4]))
    else $error("add with carry flags wrong");
  a_sbc_carry_borrow: assert property ((op == mab_pkg::OP_SBC)
    |=> {carry_reg, work_reg} == {1'b0, $past(fr)} + {1'b0, ~$past(work_reg)}
        + {8'h00, $past(carry_reg)} || $past(dest_file))
    else $error("subtract with carry wrong");
  a_skip_clear_slot: assert property (op == mab_pkg::OP_BTSC && !tbit
    |=> discard_reg ##2 !discard_reg)
    else $error("skip if clear did not discard one slot");
  a_skip_set_slot: assert property ((op == mab_pkg::OP_BTSS)
    |=> discard_reg == $past(tbit) && $stable({carry_reg, half_reg,
        zero_reg}))
    else $error("skip if set slot or flags wrong");
  a_dest_work_only: assert property ((op inside {mab_pkg::OP_ADC,
    mab_pkg::OP_SBC}) && !dest_file |-> !rf.we)
    else $error("file written with destination zero");
  a_dest_file_back: assert property ((op inside {mab_pkg::OP_ADC,
    mab_pkg::OP_SBC}) && dest_file
    |-> rf.we && rf.wdata == alu_res ##1 $stable(work_reg))
    else $error("file write back missing");
  a_call_push_pc: assert property ((op == mab_pkg::OP_CALLS)
    |-> o_push && o_push_addr == pc_reg + PC_W'(1)
    ##1 discard_reg [*2] ##1 !discard_reg)
    else $error("short call push or length wrong");
  a_call_page_bits: assert property ((op == mab_pkg::OP_CALLS)
    |=> pc_reg[mab_pkg::PAGE_HI] == $past(i_page_bit)
        && !pc_reg[mab_pkg::PAGE_LO]
        && pc_reg[7:0] == $past(instr_reg[7:0]))
    else $error("short call page bits wrong");
  a_nop_holds_all: assert property ((op == mab_pkg::OP_NOP) && exec
    |-> !rf.we && !o_push ##1 $stable({work_reg, carry_reg, half_reg,
        zero_reg}) && !discard_reg)
    else $error("unknown word changed state");

  c_skip_taken:  cover property ((op == mab_pkg::OP_BTSC) && !tbit);
  c_adc_to_file: cover property ((op == mab_pkg::OP_ADC) && dest_file);
  c_short_call:  cover property (op == mab_pkg::OP_CALLS);
  c_sbc_borrow:  cover property ((op == mab_pkg::OP_SBC) && !sum9[8]);

endmodule : mab_core

// ===== test/mab_prog_mem.sv
// Purpose: program memory model answering the core's fetch address
// Assumes: same-clock combinational answer, as the core expects
// Notes:   the bench fills mem by hierarchical write before reset release
`timescale 1ns/10ps
module mab_prog_mem #(
  parameter int PC_W = 11
) (
  // fetch address from the core
  input  wire logic [PC_W-1:0] i_pc,
  // instruction word back to the core
  output logic      [13:0]     o_instr
);
  // whole pc space, so a jump anywhere fetches real contents
  logic [13:0] mem [2**PC_W];

  // ******************************************************************
  // read path
  // ******************************************************************
  // no latency: a registered answer would shift every fetch by a clock
  assign o_instr = mem[i_pc];

endmodule : mab_prog_mem

// ===== test/tb.sv
// Purpose: self-checking bench for the alu / bit-op decoder core
// Assumes: one instruction cycle is a read clock then an exec clock
// Notes:   a shadow model predicts pc, work, flags and push each cycle
`timescale 1ns/10ps
module tb;
  localparam int PC_W = 11;
  logic            i_clk        = 1'b0;
  logic            i_sys_rst    = 1'b1;
  logic            i_page_bit   = 1'b0;
  logic [13:0]     i_instr;
  logic [PC_W-1:0] o_pc;
  logic [PC_W-1:0] o_push_addr;
  logic [7:0]      o_work;
  logic            o_push;
  logic            o_carry;
  logic            o_half_carry;
  logic            o_zero;
  logic            o_cycle_done;
  logic            o_discard;
  // shadow state of the expected machine
  logic [13:0]     img [2**PC_W];
  logic [7:0]      sfile [128];
  logic [PC_W-1:0] epc, npc, epaddr, wa;
  logic [7:0]      ew;
  logic            ec, edc, ez, edisc, ndisc, epush;
  int              checks = 0;
  int              n_fail = 0;

  // 25 MHz core clock
  always #20 i_clk = ~i_clk;

  mab_core #(.PC_W(PC_W)) u_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_instr(i_instr),
    .o_pc(o_pc), .i_page_bit(i_page_bit), .o_push(o_push),
    .o_push_addr(o_push_addr), .o_work(o_work), .o_carry(o_carry),
    .o_half_carry(o_half_carry), .o_zero(o_zero),
    .o_cycle_done(o_cycle_done), .o_discard(o_discard)
  );
  mab_prog_mem #(.PC_W(PC_W)) u_mem (.i_pc(o_pc), .o_instr(i_instr));

  // ******************************************************************
  // common tasks
  // ******************************************************************
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h got %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic put(input logic [13:0] w);
    img[wa] = w;
    u_mem.mem[wa] = w;
    wa = wa + 1'b1;
  endtask : put

  task automatic clear_prog();
    for (int a = 0; a < 2**PC_W; a++)
    begin
      img[a] = 14'h0000;
      u_mem.mem[a] = 14'h0000;
    end
    wa = '0;
  endtask : clear_prog

  task automatic op_dr(input logic [5:0] op, input logic d,
                       input logic [6:0] r);
    put({op, d, r});
  endtask : op_dr

  // the file is not cleared by reset, so every bit is written
  task automatic set_reg(input logic [6:0] r, input logic [7:0] v);
    for (int b = 0; b < 8; b++)
      put({v[b] ? mab_pkg::OPC_BSET : mab_pkg::OPC_BCLR, 3'(b), r});
  endtask : set_reg

  task automatic do_reset();
    i_sys_rst = 1'b1;
    repeat (5) @(posedge i_clk);
    #1;
    check("reset_idle", 3'b000, {o_cycle_done, o_push, o_discard});
    i_sys_rst = 1'b0;
    {epc, edisc, ew, ec, edc, ez} = '0;
  endtask : do_reset

  // one expected instruction cycle, run inside its exec clock
  task automatic iss_step();
    logic [13:0] w;
    logic [7:0]  f, r;
    logic [8:0]  s;
    logic [4:0]  h;
    logic        ci;
    w = edisc ? 14'h0000 : img[epc];
    f = sfile[w[6:0]];
    r = (w[13:8] == mab_pkg::OPC_ADC) ? ew : ~ew;
    ci = (w[13:7] == mab_pkg::OPC_CMP) ? 1'b1 : ec;
    s = {1'b0, f} + {1'b0, r} + 9'(ci);
    h = {1'b0, f[3:0]} + {1'b0, r[3:0]} + 5'(ci);
    epaddr = epc + 1'b1;
    npc = epc + 1'b1;
    {epush, ndisc} = 2'b00;
    if (w[13:9] == 5'h0E)
    begin
      {ec, edc, ez} = {s[8], h[4], s[7:0] == 8'h00};
      if (w[7])
        sfile[w[6:0]] = s[7:0];
      else
        ew = s[7:0];
    end
    else if (w[13:7] == mab_pkg::OPC_CMP)
      {ec, ez} = {s[8], s[7:0] == 8'h00};
    else if (w[13:11] == 3'b101)
      sfile[w[6:0]][w[9:7]] = ~w[10];
    else if (w[13:11] == 3'b100)
      ndisc = f[w[9:7]] ^ w[10];
    else if (w[13:8] == mab_pkg::OPC_CALLS)
      {epush, ndisc, npc} = {2'b11, 1'b0, i_page_bit, 1'b0, w[7:0]};
    else if (w[13:9] == mab_pkg::OPC_GOTOS)
      {ndisc, npc} = {1'b1, 1'b0, i_page_bit, w[8:0]};
    else if (w[13:12] == 2'b11)
      {epush, ndisc, npc} = {~w[11], 1'b1, w[10:0]};
    epc = npc;
    edisc = ndisc;
  endtask : iss_step

  task automatic run_cycles(input int n);
    repeat (n)
    begin
      check("read_state", {epc, edisc, 2'b00, ew, ec, edc, ez},
            {o_pc, o_discard, o_cycle_done, o_push, o_work, o_carry,
             o_half_carry, o_zero});
      @(posedge i_clk);
      #1;
      iss_step();
      check("exec_state", {1'b1, epush, epush ? epaddr : 11'h000},
            {o_cycle_done, o_push, epush ? o_push_addr : 11'h000});
      @(posedge i_clk);
      #1;
    end
  endtask : run_cycles

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic test_adc();
    clear_prog();
    set_reg(7'h7F, 8'h8F);
    set_reg(7'h00, 8'h34);
    repeat (2) op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h7F);
    op_dr(mab_pkg::OPC_ADC, 1'b1, 7'h7F);
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h7F);
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h00);
    op_dr(mab_pkg::OPC_ADC, 1'b1, 7'h00);
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h00);
    do_reset();
    run_cycles(25);
    $display("test adc done, %0d failures so far", n_fail);
  endtask : test_adc

  // borrow in and out, compare equal, write back to the file
  task automatic test_sbc_cmp();
    clear_prog();
    set_reg(7'h05, 8'h20);
    set_reg(7'h06, 8'h5A);
    set_reg(7'h07, 8'h59);
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h05);
    op_dr(mab_pkg::OPC_SBC, 1'b0, 7'h06);
    put({mab_pkg::OPC_CMP, 7'h06});
    op_dr(mab_pkg::OPC_SBC, 1'b1, 7'h06);
    put({mab_pkg::OPC_CMP, 7'h05});
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h05);
    put({mab_pkg::OPC_CMP, 7'h07});
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h06);
    do_reset();
    run_cycles(34);
    $display("test sbc_cmp done, %0d failures so far", n_fail);
  endtask : test_sbc_cmp

  // every bit position, both senses, then two skips back to back
  task automatic test_skip();
    clear_prog();
    set_reg(7'h09, 8'hA5);
    for (int b = 0; b < 8; b++)
    begin
      put({mab_pkg::OPC_BTSC, 3'(b), 7'h09});
      op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h09);
      put({mab_pkg::OPC_BTSS, 3'(b), 7'h09});
      op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h09);
    end
    repeat (2) put({mab_pkg::OPC_BTSC, 3'd1, 7'h09});
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h09);
    do_reset();
    run_cycles(46);
    $display("test skip done, %0d failures so far", n_fail);
  endtask : test_skip

  // target words must be discarded; the last call's return wraps to 0
  task automatic test_calls();
    for (int p = 0; p < 2; p++)
    begin
      clear_prog();
      i_page_bit = p[0];
      set_reg(7'h03, 8'h11);
      put({mab_pkg::OPC_CALLS, 8'h42});
      wa = {1'b0, p[0], 9'h042};
      op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h03);
      put({mab_pkg::OPC_LONG_CALL, 11'h5F0});
      wa = 11'h5F0;
      op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h03);
      put({mab_pkg::OPC_GOTOS, 9'h1FF});
      wa = {1'b0, p[0], 9'h1FF};
      op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h03);
      put({mab_pkg::OPC_LONG_JUMP, 11'h7FE});
      wa = 11'h7FE;
      op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h03);
      put({mab_pkg::OPC_LONG_CALL, 11'h123});
      wa = 11'h123;
      repeat (2) op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h03);
      do_reset();
      run_cycles(22);
    end
    $display("test calls done, %0d failures so far", n_fail);
  endtask : test_calls

  // carry and zero set first, so a changed flag would show
  task automatic test_nop();
    logic [13:0] odd [5] = '{14'h0000, 14'h1E05, 14'h1105, 14'h0385,
                             14'h1F7F};
    clear_prog();
    set_reg(7'h04, 8'h80);
    repeat (2) op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h04);
    foreach (odd[i]) put(odd[i]);
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h04);
    do_reset();
    run_cycles(18);
    $display("test nop done, %0d failures so far", n_fail);
  endtask : test_nop

  // reset lands in the exec clock of an add, whose result must not show
  task automatic test_reset_mid();
    clear_prog();
    set_reg(7'h02, 8'h0F);
    op_dr(mab_pkg::OPC_ADC, 1'b0, 7'h02);
    do_reset();
    run_cycles(8);
    @(posedge i_clk);
    #1;
    do_reset();
    run_cycles(10);
    $display("test reset_mid done, %0d failures so far", n_fail);
  endtask : test_reset_mid

  // ******************************************************************
  // sequence and hang guard
  // ******************************************************************
  initial
  begin
    test_adc();
    test_sbc_cmp();
    test_skip();
    test_calls();
    test_nop();
    test_reset_mid();
    print_verdict();
  end

  // a stuck run still ends in the verdict, counted as a failure
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    print_verdict();
  end

endmodule : tb
